/* logic/btc_pkg.sv */
// Constants and types for the bus trace capture block
package btc_pkg;
	// Clock and timebase
	localparam int SYS_CLK_MHZ = 200;
	localparam int SAMPLE_RATE_MHZ = 10;
	localparam int SRC_CLK_MHZ = 20;
	localparam int RT_FAST_MHZ = 10;
	localparam int RT_SLOW_MHZ = 1;
	localparam int SAMPLE_DIV = SYS_CLK_MHZ / SAMPLE_RATE_MHZ;
	localparam int SRC_DIV = SYS_CLK_MHZ / SRC_CLK_MHZ;
	localparam int RT_FAST_DIV = SRC_CLK_MHZ / RT_FAST_MHZ;
	localparam int RT_SLOW_DIV = SRC_CLK_MHZ / RT_SLOW_MHZ;
	// Widths
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int CTRL_W = 4;
	localparam int PDEP_W = 16;
	localparam int EXT_W = 4;
	localparam int ENTRY_W = 64;
	localparam int NIB_W = 4;
	localparam int NUM_RAMS = ENTRY_W / NIB_W;
	localparam int DEPTH = 256;
	localparam int PTR_W = 8;
	localparam int CNT_W = 24;
	// Control line positions in the latched control group
	localparam int CTL_A_BIT = 0;
	localparam int CTL_RW_BIT = 1;
	localparam int CTL_B_BIT = 2;
	localparam int CTL_BHE_BIT = 3;
	// Filter modes
	typedef enum logic [1:0] {
		BTC_FLT_ALL = 2'h0,
		BTC_FLT_READ_AT = 2'h1,
		BTC_FLT_WRITE_AT = 2'h2,
		BTC_FLT_NONE = 2'h3
	} btc_filter_t;
	// Counter clock selection
	typedef enum logic [1:0] {
		BTC_CSEL_10M = 2'h0,
		BTC_CSEL_1M = 2'h1,
		BTC_CSEL_BUS = 2'h2,
		BTC_CSEL_SRC = 2'h3
	} btc_csel_t;
	// Cycle counter state
	typedef enum logic [1:0] {
		BTC_CC_IDLE = 2'h0,
		BTC_CC_RUN = 2'h1,
		BTC_CC_DONE = 2'h2
	} btc_cc_t;
	// Byte select for counter readback
	localparam logic [1:0] RD_SEL_LOW = 2'h0;
	localparam logic [1:0] RD_SEL_MID = 2'h1;
	localparam logic [1:0] RD_SEL_HIGH = 2'h2;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
endpackage : btc_pkg

/* logic/btc_capture.sv */
// Bus trace capture: sampling, filtered trace RAM and cycle counter
// Summary of operation
// - Sample monitored inputs at ten megasamples per second
// - Latch samples synchronously, write into trace memory
// - Up to 256 entries of bus and side lines
// - Filter register decides which cycles are stored
// - Recording begins on external trigger event
// - 24-bit counter runs from breakpoint one to two
// - Sixteen 256x4 RAMs form a 64-bit entry
// - Optionally store only read or write at address
// - Two cascaded 4-bit counters address trace memory
// - Latch address, data and four control lines
// - Also sample processor-dependent and external inputs
// - 20 MHz source, 10/1 MHz timebase, clock selector
// - Counter returned over low eight data lines
`timescale 1ns/1ps
module btc_capture #(
	parameter int DEPTH = btc_pkg::DEPTH
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Emulated processor bus
	input wire logic [btc_pkg::ADDR_W-1:0] bus_address_lines_i,
	input wire logic [btc_pkg::DATA_W-1:0] bus_data_lines_i,
	input wire logic cpu_control_a_i,
	input wire logic read_write_n_i,
	input wire logic cpu_control_b_i,
	input wire logic byte_high_enable_i,
	input wire logic bus_cycle_i,
	// Side inputs
	input wire logic [btc_pkg::PDEP_W-1:0] processor_dependent_inputs_i,
	input wire logic [btc_pkg::EXT_W-1:0] external_condition_inputs_i,
	// Breakpoint card events
	input wire logic trigger_i,
	input wire logic breakpoint_1_i,
	input wire logic breakpoint_2_i,
	// Host control
	input wire logic arm_i,
	input wire logic [1:0] filter_mode_i,
	input wire logic [btc_pkg::ADDR_W-1:0] filter_address_i,
	input wire logic [1:0] clock_select_i,
	input wire logic counter_clear_i,
	// Host trace readback
	input wire logic [btc_pkg::PTR_W-1:0] trace_read_addr_i,
	output logic [btc_pkg::ENTRY_W-1:0] trace_read_data_o,
	// Host counter readback
	input wire logic [1:0] count_byte_sel_i,
	output logic [7:0] count_byte_o,
	// Status
	output logic recording_o,
	output logic trace_full_o,
	output logic [btc_pkg::PTR_W-1:0] entry_count_o,
	output logic counter_running_o,
	output logic counter_done_o
);
	localparam int SDIV_W = $clog2(btc_pkg::SAMPLE_DIV);
	localparam int RDIV_W = $clog2(btc_pkg::RT_SLOW_DIV * btc_pkg::SRC_DIV);
	localparam logic [SDIV_W-1:0] SDIV_LAST =
		SDIV_W'(btc_pkg::SAMPLE_DIV - 1);
	localparam logic [RDIV_W-1:0] SRC_LAST = RDIV_W'(btc_pkg::SRC_DIV - 1);
	localparam logic [RDIV_W-1:0] FAST_LAST =
		RDIV_W'(btc_pkg::RT_FAST_DIV * btc_pkg::SRC_DIV - 1);
	localparam logic [RDIV_W-1:0] SLOW_LAST =
		RDIV_W'(btc_pkg::RT_SLOW_DIV * btc_pkg::SRC_DIV - 1);

	// One 256x4 array per nibble lane
	logic [btc_pkg::NIB_W-1:0] ram [btc_pkg::NUM_RAMS][DEPTH];

	function automatic logic tick(input logic [RDIV_W-1:0] cnt,
			input logic [RDIV_W-1:0] last);
		tick = (cnt == last);
	endfunction : tick

	// Sample strobe, input latches
	logic [SDIV_W-1:0] sdiv, next_sdiv;
	logic sample_stb;
	logic [btc_pkg::ENTRY_W-1:0] latch, next_latch;
	logic latch_vld, next_latch_vld;
	logic bus_prev, next_bus_prev;

	// Timebase dividers
	logic [RDIV_W-1:0] src_cnt, next_src_cnt;
	logic [RDIV_W-1:0] fast_cnt, next_fast_cnt;
	logic [RDIV_W-1:0] slow_cnt, next_slow_cnt;

	// Trace store state
	logic [3:0] addr_lo, next_addr_lo;
	logic [3:0] addr_hi, next_addr_hi;
	logic armed, next_armed;
	logic rec, next_rec;
	logic full, next_full;
	logic store_ok;
	logic [btc_pkg::PTR_W-1:0] wptr;

	// Cycle counter state
	btc_pkg::btc_cc_t cc_st, next_cc_st;
	logic [btc_pkg::CNT_W-1:0] cyc, next_cyc;
	logic cnt_tick;
	logic [7:0] next_count_byte;
	logic [btc_pkg::ENTRY_W-1:0] next_rd_data;

	assign sample_stb = (sdiv == SDIV_LAST);
	assign wptr = {addr_hi, addr_lo};

	always_comb begin
		next_sdiv = sample_stb ? '0 : SDIV_W'(sdiv + 1'b1);
		next_latch = latch;
		next_latch_vld = 1'b0;
		next_bus_prev = bus_prev;
		if (sample_stb) begin
			next_latch = {external_condition_inputs_i,
				processor_dependent_inputs_i,
				byte_high_enable_i, cpu_control_b_i,
				read_write_n_i, cpu_control_a_i,
				bus_data_lines_i, bus_address_lines_i};
			next_latch_vld = 1'b1;
		end
		next_src_cnt = tick(src_cnt, SRC_LAST) ? '0 : RDIV_W'(src_cnt + 1'b1);
		next_fast_cnt = tick(fast_cnt, FAST_LAST) ? '0 :
			RDIV_W'(fast_cnt + 1'b1);
		next_slow_cnt = tick(slow_cnt, SLOW_LAST) ? '0 :
			RDIV_W'(slow_cnt + 1'b1);
		next_bus_prev = bus_cycle_i;
	end

	// Filter on the latched word
	always_comb begin
		logic [btc_pkg::ADDR_W-1:0] a;
		logic rd;
		a = latch[btc_pkg::ADDR_W-1:0];
		rd = latch[btc_pkg::ADDR_W + btc_pkg::DATA_W + btc_pkg::CTL_RW_BIT];
		case (btc_pkg::btc_filter_t'(filter_mode_i))
			btc_pkg::BTC_FLT_ALL: store_ok = 1'b1;
			btc_pkg::BTC_FLT_READ_AT:
				store_ok = rd && (a == filter_address_i);
			btc_pkg::BTC_FLT_WRITE_AT:
				store_ok = !rd && (a == filter_address_i);
			default: store_ok = 1'b0;
		endcase
	end

	// Trace control
	always_comb begin
		next_addr_lo = addr_lo;
		next_addr_hi = addr_hi;
		next_armed = armed;
		next_rec = rec;
		next_full = full;
		if (arm_i) begin
			// Rearm restarts the address counters
			next_armed = 1'b1;
			next_rec = 1'b0;
			next_full = 1'b0;
			next_addr_lo = '0;
			next_addr_hi = '0;
		end else begin
			if (armed && !rec && trigger_i) begin
				next_rec = 1'b1;
				next_armed = 1'b0;
			end
			if (rec && latch_vld && store_ok && !full) begin
				next_addr_lo = addr_lo + 4'h1;
				if (addr_lo == 4'hf) begin
					next_addr_hi = addr_hi + 4'h1;
				end
				if (wptr == btc_pkg::PTR_W'(DEPTH - 1)) begin
					next_full = 1'b1;
					next_rec = 1'b0;
				end
			end
		end
	end

	// Cycle counter
	always_comb begin
		case (btc_pkg::btc_csel_t'(clock_select_i))
			btc_pkg::BTC_CSEL_10M: cnt_tick = tick(fast_cnt, FAST_LAST);
			btc_pkg::BTC_CSEL_1M: cnt_tick = tick(slow_cnt, SLOW_LAST);
			btc_pkg::BTC_CSEL_BUS: cnt_tick = bus_cycle_i && !bus_prev;
			default: cnt_tick = tick(src_cnt, SRC_LAST);
		endcase
		next_cc_st = cc_st;
		next_cyc = cyc;
		case (cc_st)
			btc_pkg::BTC_CC_IDLE: begin
				if (breakpoint_1_i) begin
					next_cc_st = btc_pkg::BTC_CC_RUN;
					next_cyc = '0;
				end
			end
			btc_pkg::BTC_CC_RUN: begin
				if (breakpoint_2_i) begin
					next_cc_st = btc_pkg::BTC_CC_DONE;
				end else if (cnt_tick) begin
					next_cyc = btc_pkg::CNT_W'(cyc + 1'b1);
				end
			end
			default: begin
				next_cc_st = btc_pkg::BTC_CC_DONE;
			end
		endcase
		if (counter_clear_i) begin
			next_cc_st = btc_pkg::BTC_CC_IDLE;
			next_cyc = '0;
		end
		// Bytes are only coherent once the counter has stopped
		if (count_byte_sel_i == btc_pkg::RD_SEL_LOW) begin
			next_count_byte = cyc[7:0];
		end else if (count_byte_sel_i == btc_pkg::RD_SEL_MID) begin
			next_count_byte = cyc[15:8];
		end else if (count_byte_sel_i == btc_pkg::RD_SEL_HIGH) begin
			next_count_byte = cyc[23:16];
		end else begin
			next_count_byte = btc_pkg::RD_UNMAPPED;
		end
		for (int i = 0; i < btc_pkg::NUM_RAMS; i++) begin
			next_rd_data[i*btc_pkg::NIB_W +: btc_pkg::NIB_W] =
				ram[i][trace_read_addr_i];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			sdiv <= '0;
			latch <= '0;
			latch_vld <= 1'b0;
			bus_prev <= 1'b0;
			src_cnt <= '0;
			fast_cnt <= '0;
			slow_cnt <= '0;
			addr_lo <= '0;
			addr_hi <= '0;
			armed <= 1'b0;
			rec <= 1'b0;
			full <= 1'b0;
			cc_st <= btc_pkg::BTC_CC_IDLE;
			cyc <= '0;
			count_byte_o <= '0;
			trace_read_data_o <= '0;
		end else begin
			sdiv <= next_sdiv;
			latch <= next_latch;
			latch_vld <= next_latch_vld;
			bus_prev <= next_bus_prev;
			src_cnt <= next_src_cnt;
			fast_cnt <= next_fast_cnt;
			slow_cnt <= next_slow_cnt;
			addr_lo <= next_addr_lo;
			addr_hi <= next_addr_hi;
			armed <= next_armed;
			rec <= next_rec;
			full <= next_full;
			cc_st <= next_cc_st;
			cyc <= next_cyc;
			count_byte_o <= next_count_byte;
			trace_read_data_o <= next_rd_data;
		end
	end

	// Trace RAM write; no reset so it maps onto block memory
	always_ff @(posedge sys_clk_i) begin
		if (rst_n_i && !arm_i && rec && latch_vld && store_ok && !full) begin
			for (int i = 0; i < btc_pkg::NUM_RAMS; i++) begin
				ram[i][wptr] <= latch[i*btc_pkg::NIB_W +: btc_pkg::NIB_W];
			end
		end
	end

	assign recording_o = rec;
	assign trace_full_o = full;
	assign entry_count_o = wptr;
	assign counter_running_o = (cc_st == btc_pkg::BTC_CC_RUN);
	assign counter_done_o = (cc_st == btc_pkg::BTC_CC_DONE);
endmodule : btc_capture

/* tb/btc_capture_checker.sv */
// Port assertions for the trace capture block
`timescale 1ns/1ps
module btc_capture_checker (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Controls and events
	input wire logic arm_i,
	input wire logic trigger_i,
	input wire logic breakpoint_1_i,
	input wire logic breakpoint_2_i,
	input wire logic counter_clear_i,
	// Status
	input wire logic recording_o,
	input wire logic trace_full_o,
	input wire logic [7:0] entry_count_o,
	input wire logic counter_running_o,
	input wire logic counter_done_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_ARM: assert property (arm_i |=> entry_count_o == 8'h00)
		else $error("arm kept count");
	AST_STEP: assert property ($changed(entry_count_o) |->
		entry_count_o == $past(entry_count_o) + 8'h01 || $past(arm_i))
		else $error("count jump");
	AST_FULL: assert property (trace_full_o |-> !recording_o)
		else $error("full still records");
	AST_RATE: assert property ($changed(entry_count_o) && !$past(arm_i)
		|=> ($stable(entry_count_o) || $past(arm_i)) [*8])
		else $error("stores too close");
	AST_TRIG: assert property ($rose(recording_o) |-> $past(trigger_i))
		else $error("no trigger");
	AST_BP1: assert property ($rose(counter_running_o) |->
		$past(breakpoint_1_i)) else $error("run without start");
	AST_BP2: assert property (counter_running_o && breakpoint_2_i &&
		!counter_clear_i |=> counter_done_o && !counter_running_o)
		else $error("stop ignored");
	AST_CLR: assert property (counter_clear_i |=>
		!counter_running_o && !counter_done_o) else $error("clear");
	cover property ($rose(trace_full_o));
	cover property ($rose(counter_done_o));
	cover property ($rose(recording_o));
endmodule : btc_capture_checker
bind btc_capture btc_capture_checker chk_u (.sys_clk_i, .rst_n_i, .arm_i,
	.trigger_i, .breakpoint_1_i, .breakpoint_2_i, .counter_clear_i,
	.recording_o, .trace_full_o, .entry_count_o, .counter_running_o,
	.counter_done_o);

/* tb/btc_target_model.sv */
// Target bus model: one bus cycle per 20 clocks
`timescale 1ns/1ps
module btc_target_model (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Bus
	output logic [23:0] addr_o,
	output logic [15:0] data_o,
	output logic rw_o,
	output logic bus_cycle_o
);
	logic [4:0] ph;
	logic [7:0] n;
	// Moves mid-window, clear of the sampling edge
	always_ff @(negedge sys_clk_i) begin
		if (!rst_n_i || ph == 5'h13)
			ph <= 5'h00;
		else
			ph <= ph + 5'h01;
		if (!rst_n_i)
			n <= 8'h00;
		else if (ph == 5'h09)
			n <= n + 8'h01;
	end
	assign addr_o = {16'h5a00, n};
	assign data_o = {n, ~n};
	assign rw_o = n[0];
	assign bus_cycle_o = ph < 5'h0a;
endmodule : btc_target_model

/* tb/btc_capture_tb.sv */
// Bench for the trace capture block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("Error %0t: got %h want %h", $time, a, e); end end
module btc_capture_tb;
	logic sys_clk_i = 1'b0, rst_n_i = 1'b0;
	logic [23:0] bus_address_lines_i, filter_address_i = 24'h000000;
	logic [15:0] bus_data_lines_i, processor_dependent_inputs_i;
	logic read_write_n_i, bus_cycle_i, cpu_control_a_i, cpu_control_b_i;
	logic byte_high_enable_i, trigger_i = 1'b0, arm_i = 1'b0;
	logic breakpoint_1_i = 1'b0, breakpoint_2_i = 1'b0;
	logic counter_clear_i = 1'b0;
	logic [3:0] external_condition_inputs_i;
	logic [1:0] filter_mode_i = 2'h0, clock_select_i = 2'h0;
	logic [1:0] count_byte_sel_i = 2'h0;
	logic [7:0] trace_read_addr_i = 8'h00, count_byte_o, entry_count_o, n0;
	logic [63:0] trace_read_data_o;
	logic recording_o, trace_full_o, counter_running_o, counter_done_o;
	int checks = 0, n_mismatch = 0;
	always #2.5 sys_clk_i = ~sys_clk_i;
	assign cpu_control_a_i = bus_address_lines_i[1];
	assign cpu_control_b_i = bus_address_lines_i[2];
	assign byte_high_enable_i = bus_address_lines_i[3];
	assign processor_dependent_inputs_i = ~bus_data_lines_i;
	assign external_condition_inputs_i = bus_address_lines_i[3:0];
	btc_target_model tgt_u (.sys_clk_i, .rst_n_i,
		.addr_o(bus_address_lines_i), .data_o(bus_data_lines_i),
		.rw_o(read_write_n_i), .bus_cycle_o(bus_cycle_i));
	btc_capture dut_u (.sys_clk_i, .rst_n_i, .bus_address_lines_i,
		.bus_data_lines_i, .cpu_control_a_i, .read_write_n_i,
		.cpu_control_b_i, .byte_high_enable_i, .bus_cycle_i,
		.processor_dependent_inputs_i, .external_condition_inputs_i,
		.trigger_i, .breakpoint_1_i, .breakpoint_2_i, .arm_i,
		.filter_mode_i, .filter_address_i, .clock_select_i,
		.counter_clear_i, .trace_read_addr_i, .trace_read_data_o,
		.count_byte_sel_i, .count_byte_o, .recording_o, .trace_full_o,
		.entry_count_o, .counter_running_o, .counter_done_o);
	function automatic logic [63:0] exp_e(input logic [7:0] n);
		return {n[3:0], ~n, n, n[3], n[2], n[0], n[1], n, ~n, 16'h5a00, n};
	endfunction : exp_e
	task automatic test_done;
		$display("TB: checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge sys_clk_i);
		s = 1'b0;
	endtask : pulse
	task automatic till_cnt(input logic [7:0] k, input int lim);
		int i;
		for (i = 0; i < lim && entry_count_o !== k; i++)
			@(negedge sys_clk_i);
		if (i == lim) begin
			`CHK(1'b0, 1'b1)
			test_done();
		end
	endtask : till_cnt
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] n);
		trace_read_addr_i = a;
		@(negedge sys_clk_i);
		`CHK(trace_read_data_o, exp_e(n))
	endtask : rd_chk
	task automatic t_capture;
		logic [7:0] nt;
		pulse(arm_i);
		repeat (60) @(negedge sys_clk_i);
		`CHK(entry_count_o, 8'h00)
		`CHK(recording_o, 1'b0)
		nt = bus_address_lines_i[7:0];
		pulse(trigger_i);
		`CHK(recording_o, 1'b1)
		till_cnt(8'h04, 200);
		trace_read_addr_i = 8'h00;
		@(negedge sys_clk_i);
		n0 = trace_read_data_o[7:0];
		`CHK(8'(n0 - nt) <= 8'h02, 1'b1)
		for (int i = 0; i < 4; i++)
			rd_chk(i[7:0], n0 + i[7:0]);
		$display("capture test end");
	endtask : t_capture
	task automatic t_full;
		till_cnt(8'hff, 6000);
		till_cnt(8'h00, 40);
		`CHK(trace_full_o, 1'b1)
		`CHK(recording_o, 1'b0)
		repeat (60) @(negedge sys_clk_i);
		`CHK(entry_count_o, 8'h00)
		rd_chk(8'hff, n0 + 8'hff);
		rd_chk(8'h00, n0);
		$display("full test end");
	endtask : t_full
	task automatic t_filter;
		logic [7:0] t;
		for (int m = 1; m < 4; m++) begin
			filter_mode_i = m[1:0];
			t = bus_address_lines_i[7:0] + 8'h04;
			if (t[0] !== (m == 1))
				t = t + 8'h01;
			filter_address_i = {16'h5a00, t};
			pulse(arm_i);
			@(negedge sys_clk_i);
			pulse(trigger_i);
			repeat (240) @(negedge sys_clk_i);
			`CHK(entry_count_o, (m == 3) ? 8'h00 : 8'h01)
			if (m < 3)
				rd_chk(8'h00, t);
		end
		$display("filter test end");
	endtask : t_filter
	task automatic t_counter;
		logic [31:0] v;
		int lo[4] = '{9, 0, 9, 19};
		for (int c = 0; c < 4; c++) begin
			clock_select_i = c[1:0];
			pulse(counter_clear_i);
			pulse(breakpoint_1_i);
			`CHK(counter_running_o, 1'b1)
			repeat (199) @(negedge sys_clk_i);
			pulse(breakpoint_2_i);
			pulse(breakpoint_1_i);
			`CHK(counter_done_o, 1'b1)
			for (int b = 0; b < 4; b++) begin
				count_byte_sel_i = b[1:0];
				@(negedge sys_clk_i);
				v[b*8 +: 8] = count_byte_o;
			end
			`CHK(v[31:8], 24'h000000)
			`CHK(v[7:0] >= lo[c] && v[7:0] <= lo[c] + 2, 1'b1)
		end
		$display("counter test end");
	endtask : t_counter
	initial begin
		repeat (4) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		t_capture();
		t_full();
		t_filter();
		t_counter();
		test_done();
	end
endmodule : btc_capture_tb
